// *** bench/eetc_host_model.sv ***
// host controller model on the flash bus: chip select, link clock, strobe watch
// assumes the bench calls its tasks; link clock stands low outside frames
module eetc_host_model (
  // pins toward the flash
  output logic        link_cs_n_o = 1'h1,
  output logic        link_ck_o   = 1'h0,
  // strobe from the flash
  input  wire logic   strobe_i,
  input  wire logic   strobe_oe_i,
  // strobe activity seen by the host
  output logic [15:0] edges_o     = 16'h0000,
  output logic        bus_err_o   = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int          silent = 0;        // link cycles without a strobe edge
  logic [15:0] last   = 16'h0000; // edge count at the previous link edge
  // count strobe edges only while the flash drives the line
  always @(strobe_i)
    if (strobe_oe_i)
      edges_o = edges_o + 16'h0001;
  // a strobe silent for too long is taken as a stalled read;
  // select falling with the link clock low starts a fresh count
  always @(posedge link_ck_o or negedge link_cs_n_o)
  begin
    silent    = (edges_o != last || !link_ck_o) ? 0 : silent + 1;
    last      = edges_o;
    bus_err_o = (silent > eetc_pkg::HOST_STALL_CYC);
  end
  // odd offset keeps the frame unrelated to the system clock phase
  task automatic frame_open();
    #3 link_cs_n_o = 1'h0;
  endtask
  // 160 ns link clock, only inside a frame
  task automatic run_ck(input int n);
    repeat (n)
    begin
      #80 link_ck_o = 1'h1;
      #80 link_ck_o = 1'h0;
    end
  endtask
  task automatic frame_close();
    #40 link_cs_n_o = 1'h1;
  endtask
endmodule

// *** bench/eetc_trap_counter_properties.sv ***
// port assertions for the ecc trap and counter block
// assumes a bind onto eetc_trap_counter, one clock domain
module eetc_trap_counter_properties #(
  parameter int DENSITY_MB = eetc_pkg::DENS_512
) (
  // clock and reset
  input wire logic                        clk_sys_i,
  input wire logic                        sys_rst_i,
  // flash bus pins
  input wire logic                        link_cs_n_i,
  input wire logic                        link_ck_i,
  input wire logic                        read_write_strobe_o,
  input wire logic                        read_write_strobe_oe_o,
  // read path reports
  input wire logic                        data_phase_i,
  input wire logic                        hp_valid_i,
  input wire logic [eetc_pkg::ADDR_W-1:0] hp_addr_i,
  input wire logic                        hp_err1_i,
  input wire logic                        hp_err2_i,
  input wire logic                        hp_multi_prog_i,
  // overlay, commands, configuration
  input wire logic                        address_space_overlay_i,
  input wire logic                        ecc_overlay_i,
  input wire logic                        ecc_overlay_exit_i,
  input wire logic                        cnt_clr_cmd_i,
  input wire logic                        cnt_rd_cmd_i,
  input wire logic                        trap_two_only_i,
  input wire logic                        ded_off_i,
  input wire logic                        stall_off_i,
  // readable state
  input wire logic [15:0]                 ecc_status_word_o,
  input wire logic [15:0]                 ecc_fail_addr_low_o,
  input wire logic [15:0]                 ecc_fail_addr_high_o,
  input wire logic                        ecc_addr_trap_valid_o,
  input wire logic [eetc_pkg::CNT_W-1:0]  err_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // high register width, a16 up to the top bit of this density
  localparam int HI_W = (DENSITY_MB == eetc_pkg::DENS_128) ? eetc_pkg::TOP_128 + 1 :
    (DENSITY_MB == eetc_pkg::DENS_256) ? eetc_pkg::TOP_256 + 1 : eetc_pkg::TOP_512 + 1;
  // a double error that the block must act on; overlays are excluded
  logic chk_err2;
  assign chk_err2 = hp_valid_i && hp_err2_i && !(ded_off_i && hp_multi_prog_i)
    && !address_space_overlay_i && !ecc_overlay_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  a_valid_follows_bits: assert property (ecc_addr_trap_valid_o ==
    (ecc_status_word_o[3] | ecc_status_word_o[4]))
    else $error("trap valid differs from status bits");
  a_addr_zero_bits: assert property (ecc_fail_addr_low_o[2:0] == 3'h0 &&
    (ecc_fail_addr_high_o >> HI_W) == 16'h0000)
    else $error("trap register has bits outside the address");
  a_trap_first_capture: assert property (chk_err2 && !ecc_addr_trap_valid_o && !ecc_overlay_exit_i |=>
    ecc_fail_addr_low_o == {$past(hp_addr_i[12:0]), 3'h0} &&
    ecc_fail_addr_high_o[HI_W-1:0] == $past(hp_addr_i[HI_W+12:13]))
    else $error("first double error address not trapped");
  a_trap_hold_full: assert property (ecc_addr_trap_valid_o &&
    {ecc_fail_addr_high_o, ecc_fail_addr_low_o} != 32'h0 && !ecc_overlay_exit_i |=>
    $stable(ecc_fail_addr_low_o) && $stable(ecc_fail_addr_high_o))
    else $error("filled trap was overwritten");
  a_ded_bit_set: assert property (chk_err2 |=> ecc_status_word_o[4])
    else $error("double detection bit not set");
  a_bits_persist: assert property (!ecc_overlay_exit_i |=>
    ($past(ecc_status_word_o[4:3]) & ~ecc_status_word_o[4:3]) == 2'h0)
    else $error("status bit dropped without exit");
  a_exit_clears_all: assert property (ecc_overlay_exit_i && !hp_valid_i |=>
    ecc_status_word_o == 16'h0000 && ecc_fail_addr_low_o == 16'h0000 && ecc_fail_addr_high_o == 16'h0000)
    else $error("overlay exit left trap state");
  a_count_hold: assert property (!(cnt_rd_cmd_i && ecc_overlay_i) |=> $stable(err_count_o))
    else $error("count output moved without read in overlay");
  a_stall_low: assert property (chk_err2 && !stall_off_i && read_write_strobe_oe_o |=>
    !read_write_strobe_o until !read_write_strobe_oe_o)
    else $error("strobe moved during stall");
  a_deselect_release: assert property (link_cs_n_i [*5] |-> !read_write_strobe_oe_o && !read_write_strobe_o)
    else $error("strobe still driven after deselect");
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the ecc trap and counter block, 256 Mb build
// assumes the host model drives the link pins
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'h0, sys_rst_i = 1'h1, link_cs_n_i, link_ck_i;
  logic        read_write_strobe_o, read_write_strobe_oe_o, ecc_addr_trap_valid_o, bus_err;
  logic        data_phase_i = 1'h0, hp_valid_i = 1'h0, hp_err1_i = 1'h0, hp_err2_i = 1'h0;
  logic        hp_multi_prog_i = 1'h0, address_space_overlay_i = 1'h0, ecc_overlay_i = 1'h0;
  logic        ecc_overlay_exit_i = 1'h0, cnt_clr_cmd_i = 1'h0, cnt_rd_cmd_i = 1'h0;
  logic        trap_two_only_i = 1'h1, ded_off_i = 1'h0, stall_off_i = 1'h0;
  logic [21:0] hp_addr_i = 22'h000000;
  logic [15:0] ecc_status_word_o, ecc_fail_addr_low_o, ecc_fail_addr_high_o, err_count_o, edges, e0;
  logic [15:0] cnt_exp = 16'h0000; // count the bench expects
  int          failures = 0, checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  eetc_trap_counter #(.DENSITY_MB(eetc_pkg::DENS_256)) u_eetc_trap_counter (.*);
  eetc_host_model u_eetc_host_model (.link_cs_n_o(link_cs_n_i), .link_ck_o(link_ck_i),
    .strobe_i(read_write_strobe_o), .strobe_oe_i(read_write_strobe_oe_o), .edges_o(edges), .bus_err_o(bus_err));
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one half-page report
  task automatic hp(input logic [21:0] a, input logic e1, input logic e2);
    hp_addr_i  = a;
    hp_err1_i  = e1;
    hp_err2_i  = e2;
    hp_valid_i = 1'h1;
    step(1);
    {hp_valid_i, hp_err1_i, hp_err2_i} = 3'h0;
    step(1);
  endtask
  task automatic leave_overlay();
    ecc_overlay_exit_i = 1'h1;
    step(1);
    ecc_overlay_exit_i = 1'h0;
    step(1);
  endtask
  // counter command, with or without the ecc overlay entered
  task automatic cmd(input logic ovl, input logic clr);
    ecc_overlay_i = ovl;
    {cnt_clr_cmd_i, cnt_rd_cmd_i} = {clr, !clr};
    step(1);
    {cnt_clr_cmd_i, cnt_rd_cmd_i, ecc_overlay_i} = 3'h0;
    step(2);
  endtask
  task automatic rd_count();
    cmd(1'h1, 1'h0);
    chk("count", cnt_exp, err_count_o);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    step(3);
    sys_rst_i = 1'h0;
    step(2);
    chk("status", 16'h0000, ecc_status_word_o);
    rd_count();
    // double-only trap: single error flags but is not trapped
    hp(22'h000777, 1'h1, 1'h0);
    chk("status", 16'h0008, ecc_status_word_o);
    chk("low", 16'h0000, ecc_fail_addr_low_o);
    hp(22'h3F1235, 1'h0, 1'h1);
    hp(22'h001111, 1'h0, 1'h1);
    chk("low", {13'h1235, 3'h0}, ecc_fail_addr_low_o);
    chk("high", 16'h00F8, ecc_fail_addr_high_o);
    chk("status", 16'h0018, ecc_status_word_o);
    chk("valid", 16'h0001, {15'h0, ecc_addr_trap_valid_o});
    cnt_exp = 16'h0003;
    leave_overlay();
    chk("trap", 16'h0000, ecc_fail_addr_low_o | ecc_fail_addr_high_o | ecc_status_word_o);
    rd_count();
    // single errors trapped when the trap-type bit is clear
    trap_two_only_i = 1'h0;
    hp(22'h012ABC, 1'h1, 1'h0);
    chk("low", {13'h0ABC, 3'h0}, ecc_fail_addr_low_o);
    leave_overlay();
    {ded_off_i, hp_multi_prog_i} = 2'h3;
    hp(22'h3F1235, 1'h0, 1'h1);
    chk("status", 16'h0000, ecc_status_word_o);
    {ded_off_i, hp_multi_prog_i} = 2'h0;
    address_space_overlay_i = 1'h1;
    hp(22'h000777, 1'h1, 1'h0);
    address_space_overlay_i = 1'h0;
    ecc_overlay_i = 1'h1;
    hp(22'h000777, 1'h1, 1'h0);
    ecc_overlay_i = 1'h0;
    cnt_exp = 16'h0004;
    rd_count();
    // commands outside the overlay are ignored
    hp(22'h000777, 1'h1, 1'h0);
    cmd(1'h0, 1'h0);
    chk("count", cnt_exp, err_count_o);
    cmd(1'h0, 1'h1);
    cnt_exp = 16'h0005;
    rd_count();
    cmd(1'h1, 1'h1);
    cnt_exp = 16'h0000;
    rd_count();
    // stalled read: strobe held low, counting goes on
    leave_overlay();
    u_eetc_host_model.frame_open();
    step(1);
    data_phase_i = 1'h1;
    fork
      u_eetc_host_model.run_ck(60);
      begin
        step(60);
        chk("strobe live", 16'h0001, {15'h0, edges != 16'h0000});
        hp(22'h000100, 1'h0, 1'h1);
        step(3);
        e0 = edges;
        chk("strobe", 16'h0000, {15'h0, read_write_strobe_o});
        hp(22'h000200, 1'h1, 1'h0);
        hp(22'h000200, 1'h1, 1'h0);
        step(200);
        chk("edges", e0, edges);
      end
    join
    chk("bus error", 16'h0001, {15'h0, bus_err});
    u_eetc_host_model.frame_close();
    data_phase_i = 1'h0;
    step(6);
    chk("oe", 16'h0000, {15'h0, read_write_strobe_oe_o});
    cnt_exp = 16'h0002;
    rd_count();
    // stall disabled: strobe keeps moving, same half-page counts again
    stall_off_i = 1'h1;
    u_eetc_host_model.frame_open();
    step(1);
    data_phase_i = 1'h1;
    fork
      u_eetc_host_model.run_ck(20);
      begin
        step(60);
        hp(22'h000200, 1'h0, 1'h1);
        e0 = edges;
        step(100);
        chk("edges moving", 16'h0001, {15'h0, edges != e0});
        chk("bus error", 16'h0000, {15'h0, bus_err});
      end
    join
    u_eetc_host_model.frame_close();
    data_phase_i = 1'h0;
    step(6);
    cnt_exp = 16'h0003;
    rd_count();
    // saturation with back-to-back reports
    {hp_valid_i, hp_err1_i} = 2'h3;
    repeat (65540)
    begin
      hp_addr_i = hp_addr_i ^ 22'h000001;
      step(1);
    end
    {hp_valid_i, hp_err1_i} = 2'h0;
    step(1);
    cnt_exp = 16'hFFFF;
    rd_count();
    // mid-run hardware reset clears count, trap and status
    sys_rst_i = 1'h1;
    step(1);
    sys_rst_i = 1'h0;
    step(2);
    chk("reset trap", 16'h0000, ecc_fail_addr_low_o | ecc_fail_addr_high_o | ecc_status_word_o);
    cnt_exp = 16'h0000;
    rd_count();
    report_and_stop();
  end
  // watchdog well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge clk_sys_i);
    failures++;
    report_and_stop();
  end
endmodule
bind eetc_trap_counter eetc_trap_counter_properties #(.DENSITY_MB(DENSITY_MB)) u_props (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link_cs_n_i(link_cs_n_i), .link_ck_i(link_ck_i),
  .read_write_strobe_o(read_write_strobe_o), .read_write_strobe_oe_o(read_write_strobe_oe_o),
  .data_phase_i(data_phase_i), .hp_valid_i(hp_valid_i), .hp_addr_i(hp_addr_i), .hp_err1_i(hp_err1_i),
  .hp_err2_i(hp_err2_i), .hp_multi_prog_i(hp_multi_prog_i), .address_space_overlay_i(address_space_overlay_i),
  .ecc_overlay_i(ecc_overlay_i), .ecc_overlay_exit_i(ecc_overlay_exit_i), .cnt_clr_cmd_i(cnt_clr_cmd_i),
  .cnt_rd_cmd_i(cnt_rd_cmd_i), .trap_two_only_i(trap_two_only_i), .ded_off_i(ded_off_i), .stall_off_i(stall_off_i),
  .ecc_status_word_o(ecc_status_word_o), .ecc_fail_addr_low_o(ecc_fail_addr_low_o),
  .ecc_fail_addr_high_o(ecc_fail_addr_high_o), .ecc_addr_trap_valid_o(ecc_addr_trap_valid_o),
  .err_count_o(err_count_o));

// *** rtl/eetc_cnt_if.sv ***
// request and value lines between the trap logic and its error counter
// assumes both ends sit on the same system clock
interface eetc_cnt_if;
  logic                      inc;   // count one errored half-page
  logic                      clr;   // clear to zero
  logic [eetc_pkg::CNT_W-1:0] value; // current count
  modport ctl (output inc, output clr, input value);
  modport cnt (input inc, input clr, output value);
endinterface

// *** rtl/eetc_pkg.sv ***
// shared constants of the ecc error trap and counter block
// assumes half-page addresses arrive as 16-bit word addresses a24..a3
package eetc_pkg;
  // density choices in megabits
  localparam int DENS_128 = 128;
  localparam int DENS_256 = 256;
  localparam int DENS_512 = 512;
  // trapped word address width, a24 down to a3
  localparam int ADDR_W = 22;
  // bit index within the trapped address of a16
  localparam int ADDR_HI_POS = 13;
  // top trapped address bit per density, counted from a16
  localparam int TOP_128 = 6;
  localparam int TOP_256 = 7;
  localparam int TOP_512 = 8;
  // low trap register keeps three zero bits under a3
  localparam int LOW_ZERO_W = 3;
  // error counter width and saturation value
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;
  // status word layout
  localparam int ST_CORR_BIT = 3;
  localparam int ST_DED_BIT  = 4;
  localparam logic [15:0] ST_RST = 16'h0000;
  localparam logic [15:0] REG_RST = 16'h0000;
  // host side strobe timeout, in link clock cycles
  localparam int HOST_STALL_CYC = 32;
  // link state, gray coded along idle, selected, stalled
  typedef enum logic [1:0] {
    EETC_IDLE  = 2'b00,
    EETC_SEL   = 2'b01,
    EETC_STALL = 2'b11
  } eetc_link_t;
endpackage

// *** rtl/eetc_sat_cnt.sv ***
// saturating error counter behind the counter interface
// assumes inc and clr are single cycle requests on clk_sys_i
module eetc_sat_cnt (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  // requests and value
  eetc_cnt_if.cnt   cnt_if
);
  logic [eetc_pkg::CNT_W-1:0] cnt_r;   // count
  logic [eetc_pkg::CNT_W-1:0] cnt_nxt; // next count

  // clear beats increment; the top value holds instead of wrapping
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (cnt_if.clr)
      cnt_nxt = eetc_pkg::CNT_RST;
    else if (cnt_if.inc && (cnt_r != eetc_pkg::CNT_MAX))
      cnt_nxt = cnt_r + 16'h0001;
  end

  // register only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_r <= eetc_pkg::CNT_RST;
    else
      cnt_r <= cnt_nxt;
  end

  assign cnt_if.value = cnt_r;
endmodule

// *** rtl/eetc_sync2.sv ***
// two flop synchroniser for pins from the flash bus
// assumes the inputs are asynchronous to clk_sys_i
module eetc_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  // pins in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r; // first stage, read only by the second
  logic [W-1:0] sync_r; // second stage

  // both stages reset to the pins' idle levels, so no false edge after reset
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// *** rtl/eetc_trap_counter.sv ***
// ecc error address trap, errored half-page counter and strobe stall
// assumes the array read path reports each half-page once on clk_sys_i
//
// How it works
// - trap holds address of first enabled error
// - largest density traps double errors only
// - trap-type bit zero traps single and double
// - trap valid while status bit 3 or 4
// - trap names the aligned sixteen-byte half-page
// - earliest failing half-page kept within one read
// - later errors leave trap alone until cleared
// - overlay exit clears trap and status bits
// - double detect off plus reprogrammed: no checking
// - low register a15..a3, high a16 upward
// - smaller densities count single and double errors
// - count only main array reads, no overlay
// - counter survives exit, cleared by reset, command
// - counter commands act only inside ecc overlay
// - sixteen bit counter saturates at all ones
// - stalled read keeps counting until deselect
// - within a frame, the last counted half-page is not recounted
// - stall enabled: double error holds strobe low
// - stall disabled: strobe runs normally
// - status bits set on events, persist
module eetc_trap_counter #(
  parameter int DENSITY_MB = eetc_pkg::DENS_512
) (
  // clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        sys_rst_i,
  // flash bus pins
  input  wire logic                        link_cs_n_i,
  input  wire logic                        link_ck_i,
  output logic                             read_write_strobe_o,
  output logic                             read_write_strobe_oe_o,
  // array read path reports
  input  wire logic                        data_phase_i,
  input  wire logic                        hp_valid_i,
  input  wire logic [eetc_pkg::ADDR_W-1:0] hp_addr_i,
  input  wire logic                        hp_err1_i,
  input  wire logic                        hp_err2_i,
  input  wire logic                        hp_multi_prog_i,
  // overlay and command decode
  input  wire logic                        address_space_overlay_i,
  input  wire logic                        ecc_overlay_i,
  input  wire logic                        ecc_overlay_exit_i,
  input  wire logic                        cnt_clr_cmd_i,
  input  wire logic                        cnt_rd_cmd_i,
  // configuration bits
  input  wire logic                        trap_two_only_i,
  input  wire logic                        ded_off_i,
  input  wire logic                        stall_off_i,
  // readable state
  output logic [15:0]                      ecc_status_word_o,
  output logic [15:0]                      ecc_fail_addr_low_o,
  output logic [15:0]                      ecc_fail_addr_high_o,
  output logic                             ecc_addr_trap_valid_o,
  output logic [eetc_pkg::CNT_W-1:0]       err_count_o
);

  // largest density lacks the counter and the trap-type choice
  localparam bit IS_BIG = (DENSITY_MB == eetc_pkg::DENS_512);
  // top high register bit by density
  localparam int TOP_HI = (DENSITY_MB == eetc_pkg::DENS_128) ? eetc_pkg::TOP_128 :
                          (DENSITY_MB == eetc_pkg::DENS_256) ? eetc_pkg::TOP_256 :
                          eetc_pkg::TOP_512;

  // mask of populated high register bits
  function automatic logic [15:0] hi_mask(input int top);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i <= top; i++)
      m[i] = 1'b1;
    return m;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_s;   // synced {ck, cs_n}
  logic       cs_n_s;  // chip select, active low
  logic       ck_s;    // link clock level

  // idle levels: select high, link clock low, so reset shows no edge
  eetc_sync2 #(
    .W       (2),
    .RST_VAL (2'h1)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({link_ck_i, link_cs_n_i}),
    .sync_o    (pin_s)
  );

  assign cs_n_s = pin_s[0];
  assign ck_s   = pin_s[1];

  // ---------------------------------------------------------------
  // event qualification
  // ---------------------------------------------------------------
  logic chk_on;     // ecc checking live for this half-page
  logic any_err;    // some error on this half-page
  logic trap_hit;   // error of the enabled trap type
  logic main_rd;    // plain array read, no overlay

  // reprogrammed half-pages are unchecked with double detect off
  always_comb
  begin
    chk_on   = !(ded_off_i && hp_multi_prog_i);
    any_err  = hp_valid_i && chk_on && (hp_err1_i || hp_err2_i);
    main_rd  = !address_space_overlay_i && !ecc_overlay_i;
    if (IS_BIG || trap_two_only_i)
      trap_hit = hp_valid_i && chk_on && hp_err2_i;
    else
      trap_hit = any_err;
  end

  // ---------------------------------------------------------------
  // link state: selected / stalled
  // ---------------------------------------------------------------
  eetc_pkg::eetc_link_t link_r;   // state
  eetc_pkg::eetc_link_t link_nxt; // next state

  // deselect always wins, so stall ends exactly with the frame
  always_comb
  begin
    link_nxt = link_r;
    case (link_r)
      eetc_pkg::EETC_IDLE:
      begin
        if (!cs_n_s)
          link_nxt = eetc_pkg::EETC_SEL;
      end
      eetc_pkg::EETC_SEL:
      begin
        if (cs_n_s)
          link_nxt = eetc_pkg::EETC_IDLE;
        else if (hp_valid_i && chk_on && hp_err2_i && !stall_off_i)
          link_nxt = eetc_pkg::EETC_STALL;
      end
      eetc_pkg::EETC_STALL:
      begin
        if (cs_n_s)
          link_nxt = eetc_pkg::EETC_IDLE;
      end
      default:
        link_nxt = eetc_pkg::EETC_IDLE;
    endcase
  end

  // register only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      link_r <= eetc_pkg::EETC_IDLE;
    else
      link_r <= link_nxt;
  end

  // ---------------------------------------------------------------
  // strobe generation from link clock edges
  // ---------------------------------------------------------------
  logic ck_d_r;    // previous synced clock level
  logic ck_d_nxt;
  logic stb_r;     // normal strobe level
  logic stb_nxt;
  logic stb_out_r; // driven strobe after stall gating
  logic stb_out_nxt;
  logic oe_r;      // strobe drive enable
  logic oe_nxt;

  // strobe toggles on each link clock edge in the data phase;
  // the stall forces it low but the toggler keeps running
  always_comb
  begin
    ck_d_nxt = ck_s;
    stb_nxt  = stb_r;
    if (link_r == eetc_pkg::EETC_IDLE || !data_phase_i)
      stb_nxt = 1'b0;
    else if (ck_s != ck_d_r)
      stb_nxt = !stb_r;
    if (link_nxt == eetc_pkg::EETC_STALL)
      stb_out_nxt = 1'b0;
    else
      stb_out_nxt = stb_nxt;
    oe_nxt = (link_nxt != eetc_pkg::EETC_IDLE);
  end

  // register only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      ck_d_r    <= 1'b0;
      stb_r     <= 1'b0;
      stb_out_r <= 1'b0;
      oe_r      <= 1'b0;
    end
    else
    begin
      ck_d_r    <= ck_d_nxt;
      stb_r     <= stb_nxt;
      stb_out_r <= stb_out_nxt;
      oe_r      <= oe_nxt;
    end
  end

  assign read_write_strobe_o    = stb_out_r;
  assign read_write_strobe_oe_o = oe_r;

  // ---------------------------------------------------------------
  // status bits and address trap
  // ---------------------------------------------------------------
  logic                        corr_r;    // correction seen
  logic                        corr_nxt;
  logic                        ded_r;     // double detect seen
  logic                        ded_nxt;
  logic                        full_r;    // trap holds an address
  logic                        full_nxt;
  logic [eetc_pkg::ADDR_W-1:0] trap_r;    // trapped half-page
  logic [eetc_pkg::ADDR_W-1:0] trap_nxt;

  // exit clears, but an event in the same cycle still sets: no loss
  always_comb
  begin
    corr_nxt = corr_r && !ecc_overlay_exit_i;
    ded_nxt  = ded_r && !ecc_overlay_exit_i;
    full_nxt = full_r && !ecc_overlay_exit_i;
    trap_nxt = ecc_overlay_exit_i ? '0 : trap_r;
    if (hp_valid_i && chk_on && hp_err1_i && !hp_err2_i)
      corr_nxt = 1'b1;
    if (hp_valid_i && chk_on && hp_err2_i)
      ded_nxt = 1'b1;
    // only the first enabled error after a clear is taken; reports come
    // in address order, so the earliest half-page of a read wins
    if (trap_hit && main_rd && !full_nxt)
    begin
      full_nxt = 1'b1;
      trap_nxt = hp_addr_i;
    end
  end

  // register only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      corr_r <= 1'b0;
      ded_r  <= 1'b0;
      full_r <= 1'b0;
      trap_r <= '0;
    end
    else
    begin
      corr_r <= corr_nxt;
      ded_r  <= ded_nxt;
      full_r <= full_nxt;
      trap_r <= trap_nxt;
    end
  end

  // status word: reserved and per-unit bits read as zero here
  always_comb
  begin
    ecc_status_word_o                        = eetc_pkg::ST_RST;
    ecc_status_word_o[eetc_pkg::ST_CORR_BIT] = corr_r;
    ecc_status_word_o[eetc_pkg::ST_DED_BIT]  = ded_r;
  end

  assign ecc_addr_trap_valid_o = corr_r || ded_r;
  // word address a15..a3 lands on bits 15..3; high part masked by density
  assign ecc_fail_addr_low_o  = {trap_r[eetc_pkg::ADDR_HI_POS-1:0],
                                 {eetc_pkg::LOW_ZERO_W{1'b0}}};
  assign ecc_fail_addr_high_o = {7'h00, trap_r[eetc_pkg::ADDR_W-1:eetc_pkg::ADDR_HI_POS]}
                                & hi_mask(TOP_HI);

  // ---------------------------------------------------------------
  // per-transaction dedupe and error counter
  // ---------------------------------------------------------------
  logic                        seen_r;   // a half-page counted this frame
  logic                        seen_nxt;
  logic [eetc_pkg::ADDR_W-1:0] last_r;   // last counted half-page
  logic [eetc_pkg::ADDR_W-1:0] last_nxt;
  logic                        cnt_inc;  // counter increment request
  logic [eetc_pkg::CNT_W-1:0]  rd_r;     // value latched by read command
  logic [eetc_pkg::CNT_W-1:0]  rd_nxt;

  eetc_cnt_if u_cnt_if ();

  // count keeps going while stalled; memory forgets at deselect so a
  // fresh transaction re-counts the same faulty half-page
  always_comb
  begin
    cnt_inc  = !IS_BIG && any_err && main_rd
               && !(seen_r && last_r == hp_addr_i);
    seen_nxt = seen_r;
    last_nxt = last_r;
    if (cs_n_s)
      seen_nxt = 1'b0;
    else if (cnt_inc)
    begin
      seen_nxt = 1'b1;
      last_nxt = hp_addr_i;
    end
    rd_nxt = rd_r;
    if (cnt_rd_cmd_i && ecc_overlay_i)
      rd_nxt = u_cnt_if.value;
  end

  assign u_cnt_if.inc = cnt_inc;
  assign u_cnt_if.clr = cnt_clr_cmd_i && ecc_overlay_i;

  // register only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      seen_r <= 1'b0;
      last_r <= '0;
      rd_r   <= eetc_pkg::CNT_RST;
    end
    else
    begin
      seen_r <= seen_nxt;
      last_r <= last_nxt;
      rd_r   <= rd_nxt;
    end
  end

  eetc_sat_cnt u_cnt (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .cnt_if    (u_cnt_if.cnt)
  );

  assign err_count_o = rd_r;

endmodule
